// file: lcd_port_pkg.sv
`default_nettype none
package lcd_port_pkg;
   // Pin vector layout after the input synchronisers
   localparam int PIN_W       = 16;
   localparam int PIN_INIT    = 15;
   localparam int PIN_SEL_LOW = 14;
   localparam int PIN_SEL_HI  = 13;
   localparam int PIN_DC      = 12;
   localparam int PIN_PS      = 11;
   localparam int PIN_FAMILY  = 10;
   localparam int PIN_READ    = 9;
   localparam int PIN_WRITE   = 8;
   // Data bus and serial lanes
   localparam int BUS_W       = 8;
   localparam int SCL_BIT     = 6;
   localparam int SI_BIT      = 7;
   localparam int FIFO_W      = BUS_W + 1;
   localparam int DC_BIT      = BUS_W;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // Pin reset and drive values
   localparam logic [PIN_W-1:0] PIN_RESET = 16'h0000;
   localparam logic [BUS_W-1:0] OE_ALL    = 8'hFF;
   localparam logic [BUS_W-1:0] OE_NONE   = 8'h00;
   localparam logic [BUS_W-1:0] BYTE_ZERO = 8'h00;
   localparam logic [2:0]       CNT_ZERO  = 3'h0;
   // Bus styles
   typedef enum logic [1:0] {
      MODE_STROBE = 2'b00,
      MODE_ENABLE = 2'b01,
      MODE_SERIAL = 2'b10
   } busMode_t;
endpackage
`default_nettype wire

// file: stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface stream_if #(parameter int WIDTH = 9);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: two_entry_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer #(
   parameter int WIDTH = 9
) (
   // Clock and reset
   input  wire logic  clk_sys,
   input  wire logic  arst_n,
   input  wire logic  flush,
   // Streams
   stream_if.snk      inPort,
   stream_if.src      outPort
);
   logic [WIDTH-1:0] head;
   logic [WIDTH-1:0] tail;
   logic             headValid;
   logic             tailValid;
   logic [WIDTH-1:0] next_head;
   logic [WIDTH-1:0] next_tail;
   logic             next_headValid;
   logic             next_tailValid;
   wire              take;
   wire              give;

   // Handshakes; head is the output register
   assign take          = inPort.valid & inPort.ready;
   assign give          = headValid & outPort.ready;
   assign inPort.ready  = ~tailValid;
   assign outPort.valid = headValid;
   assign outPort.data  = head;

   // Pop moves tail up, push fills first free slot
   always_comb
   begin
      next_head      = head;
      next_tail      = tail;
      next_headValid = headValid;
      next_tailValid = tailValid;
      if (give)
      begin
         next_head      = tail;
         next_headValid = tailValid;
         next_tailValid = 1'b0;
      end
      if (take)
      begin
         if (!next_headValid)
         begin
            next_head      = inPort.data;
            next_headValid = 1'b1;
         end
         else
         begin
            next_tail      = inPort.data;
            next_tailValid = 1'b1;
         end
      end
   end

   // Storage
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         head      <= '0;
         tail      <= '0;
         headValid <= 1'b0;
         tailValid <= 1'b0;
      end
      else
      begin
         head      <= next_head;
         tail      <= next_tail;
         headValid <= next_headValid & ~flush;
         tailValid <= next_tailValid & ~flush;
      end
   end
endmodule
`default_nettype wire

// file: lcd_host_port.sv
// Contract
// - Transfers only with select low and high
// - Init pin low holds settings initialised
// - Command select high data, low command
// - Strobe mode latches on write rising edge
// - Enable mode direction high read, low write
// - Strobe mode drives bus while read low
// - Enable mode strobe pin frames each transfer
// - Eight-bit bidirectional parallel data bus
// - Serial mode floats six low lines
// - Serial clock line six, data seven
// - Deselected device floats all eight lines
// - Parallel select high parallel, low serial
// - Family select high enable, low strobe
// - Decode data, command, status, display reads
// - Serial mode is write only
`timescale 1ns/10ps
`default_nettype none
module lcd_host_port
   import lcd_port_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              arst_n,
   // Host pins
   input  wire logic              selectLowN,
   input  wire logic              selectHigh,
   input  wire logic              initN,
   input  wire logic              dataCommandSelect,
   input  wire logic              parallelSelect,
   input  wire logic              cpuFamilySelect,
   input  wire logic              readEnable,
   input  wire logic              writeDirection,
   input  wire logic [BUS_W-1:0]  dataIn,
   output var  logic [BUS_W-1:0]  dataOut,
   output var  logic [BUS_W-1:0]  dataOe,
   // Controller write stream
   output var  logic              wrValid,
   output var  logic              wrIsData,
   output var  logic [BUS_W-1:0]  wrData,
   input  wire logic              wrReady,
   // Controller read side
   output var  logic              displayRead,
   output var  logic              statusRead,
   input  wire logic [BUS_W-1:0]  displayByte,
   input  wire logic [BUS_W-1:0]  statusByte,
   // Status
   output var  logic              initActive,
   output var  logic              portBusy
);
   // Chip select decode
   function automatic logic selDecode(input logic lowN, input logic high);
      selDecode = ~lowN & high;
   endfunction

   // Bus style decode
   function automatic busMode_t modeDecode(input logic ps, input logic fam);
      busMode_t m;
      m = MODE_SERIAL;
      case ({ps, fam})
         2'b10:   m = MODE_STROBE;
         2'b11:   m = MODE_ENABLE;
         default: m = MODE_SERIAL;
      endcase
      return m;
   endfunction

   logic [PIN_W-1:0] syncA;
   logic [PIN_W-1:0] syncB;
   logic [PIN_W-1:0] syncC;
   logic [PIN_W-1:0] pinF;
   logic [PIN_W-1:0] pinPrev;
   logic [2:0]       bitCount;
   logic [6:0]       shiftReg;
   wire  [PIN_W-1:0] pinRaw;
   wire  [PIN_W-1:0] agree;
   wire  [PIN_W-1:0] next_pinF;
   wire              initLevel;
   wire              chipSel;
   busMode_t         mode;
   wire              dcNow;
   wire              sclRise;
   wire              siNow;
   wire              wrRise;
   wire              rdFall;
   wire              rdRise;
   wire              eFall;
   wire              pushStrobe;
   wire              pushEnable;
   wire              serialDone;
   wire              readReq;
   wire              pushValid;
   wire [FIFO_W-1:0] pushData;
   wire              driveBus;
   wire [BUS_W-1:0]  next_dataOe;

   stream_if #(.WIDTH(FIFO_W)) inStream ();
   stream_if #(.WIDTH(FIFO_W)) outStream ();

   // Three-stage synchronisers, change taken when stages two and three agree
   assign pinRaw = {initN, selectLowN, selectHigh, dataCommandSelect,
                    parallelSelect, cpuFamilySelect, readEnable,
                    writeDirection, dataIn};
   assign agree     = ~(syncB ^ syncC);
   assign next_pinF = (syncC & agree) | (pinF & ~agree);

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         syncA   <= PIN_RESET;
         syncB   <= PIN_RESET;
         syncC   <= PIN_RESET;
         pinF    <= PIN_RESET;
         pinPrev <= PIN_RESET;
      end
      else
      begin
         syncA   <= pinRaw;
         syncB   <= syncA;
         syncC   <= syncB;
         pinF    <= next_pinF;
         pinPrev <= pinF;
      end
   end

   // Pin decode and edge finding
   // Init stays active one cycle past its release, masking the
   // false strobe edges that follow the synchroniser reset value
   assign initLevel = ~(pinF[PIN_INIT] & pinPrev[PIN_INIT]);
   assign chipSel   = selDecode(pinF[PIN_SEL_LOW], pinF[PIN_SEL_HI]);
   assign mode      = modeDecode(pinF[PIN_PS], pinF[PIN_FAMILY]);
   assign dcNow     = pinF[PIN_DC];
   assign sclRise   = ~pinPrev[SCL_BIT] & pinF[SCL_BIT];
   assign siNow     = pinF[SI_BIT];
   assign wrRise    = ~pinPrev[PIN_WRITE] & pinF[PIN_WRITE];
   assign rdFall    = pinPrev[PIN_READ] & ~pinF[PIN_READ];
   assign rdRise    = ~pinPrev[PIN_READ] & pinF[PIN_READ];
   assign eFall     = rdFall;

   // Transfer decode per bus style
   assign pushStrobe = ~initLevel & chipSel & (mode == MODE_STROBE)
                       & wrRise;
   assign pushEnable = ~initLevel & chipSel & (mode == MODE_ENABLE)
                       & eFall & ~pinF[PIN_WRITE];
   assign serialDone = ~initLevel & chipSel & (mode == MODE_SERIAL)
                       & sclRise & (bitCount == LAST_BIT);
   assign readReq    = ~initLevel & chipSel & (
                       ((mode == MODE_STROBE) & rdFall) |
                       ((mode == MODE_ENABLE) & rdRise
                        & pinF[PIN_WRITE]));

   // Byte into the buffer, command select in the top bit
   assign pushValid = pushStrobe | pushEnable | serialDone;
   assign pushData  = serialDone ? {dcNow, shiftReg, siNow}
                                 : {dcNow, pinF[BUS_W-1:0]};
   assign inStream.valid = pushValid;
   assign inStream.data  = pushData;

   // Bus drive decode, never in serial mode
   assign driveBus = ~initLevel & chipSel & (
                     ((mode == MODE_STROBE) & ~pinF[PIN_READ]) |
                     ((mode == MODE_ENABLE) & pinF[PIN_READ]
                      & pinF[PIN_WRITE]));
   assign next_dataOe = driveBus ? OE_ALL : OE_NONE;

   // Serial shifter, MSB first
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bitCount <= CNT_ZERO;
         shiftReg <= '0;
      end
      else if (initLevel | ~chipSel | (mode != MODE_SERIAL))
      begin
         bitCount <= CNT_ZERO;
      end
      else if (sclRise)
      begin
         bitCount <= bitCount + 3'h1;
         shiftReg <= {shiftReg[5:0], siNow};
      end
   end

   // Pin outputs and read strobes
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dataOe      <= OE_NONE;
         dataOut     <= BYTE_ZERO;
         displayRead <= 1'b0;
         statusRead  <= 1'b0;
         initActive  <= 1'b1;
         portBusy    <= 1'b0;
      end
      else
      begin
         dataOe      <= next_dataOe;
         dataOut     <= dcNow ? displayByte : statusByte;
         displayRead <= readReq & dcNow;
         statusRead  <= readReq & ~dcNow;
         initActive  <= initLevel;
         portBusy    <= ~inStream.ready;
      end
   end

   // Two-entry buffer toward the controller, flushed by init
   two_entry_buffer #(.WIDTH(FIFO_W)) u_buffer (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .flush   (initLevel),
      .inPort  (inStream),
      .outPort (outStream)
   );
   assign wrValid         = outStream.valid;
   assign wrIsData        = outStream.data[DC_BIT];
   assign wrData          = outStream.data[BUS_W-1:0];
   assign outStream.ready = wrReady;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence serialLastEdge;
      !initLevel && chipSel && mode == MODE_SERIAL && sclRise
         && bitCount == LAST_BIT;
   endsequence

   sequence strobeReadOpen;
      !initLevel && chipSel && mode == MODE_STROBE && rdFall;
   endsequence

   a_deselect_float: assert property (
      !chipSel |=> dataOe == OE_NONE)
      else $error("bus driven while deselected");
   a_deselect_ignore: assert property (
      !chipSel |-> !pushValid && !readReq)
      else $error("transfer taken while deselected");
   a_init_clear: assert property (
      initLevel |=> !wrValid && bitCount == CNT_ZERO && initActive)
      else $error("init did not clear port");
   a_strobe_latch: assert property (
      pushValid && mode == MODE_STROBE |->
         !pinPrev[PIN_WRITE] && pinF[PIN_WRITE])
      else $error("strobe write off rising edge");
   a_strobe_drive: assert property (
      strobeReadOpen |=> dataOe == OE_ALL ##1 displayRead == 1'b0)
      else $error("strobe read not driven");
   a_enable_dir: assert property (
      !initLevel && chipSel && mode == MODE_ENABLE && pinF[PIN_READ]
         |=> dataOe == ($past(pinF[PIN_WRITE]) ? OE_ALL : OE_NONE))
      else $error("enable direction wrong");
   a_serial_float: assert property (
      mode == MODE_SERIAL |=> dataOe == OE_NONE && !displayRead)
      else $error("serial mode drove bus or read");
   a_serial_byte: assert property (
      serialLastEdge ##0 !wrValid |=> wrValid
         && wrData == {$past(shiftReg), $past(siNow)}
         && wrIsData == $past(dcNow))
      else $error("serial byte not assembled");
   a_read_decode: assert property (
      readReq |=> displayRead == $past(dcNow)
         && statusRead == !$past(dcNow))
      else $error("read decode wrong");
   a_mode_pick: assert property (
      pinF[PIN_PS] |-> mode == (pinF[PIN_FAMILY] ? MODE_ENABLE
                                                  : MODE_STROBE))
      else $error("bus style decode wrong");
endmodule
`default_nettype wire

// file: host_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_bus_model
   import lcd_port_pkg::*;
(
   // Clock
   input  wire logic              clk_sys,
   // Device side of the data bus
   input  wire logic [BUS_W-1:0]  dataOut,
   input  wire logic [BUS_W-1:0]  dataOe,
   // Host pins
   output var  logic              selectLowN,
   output var  logic              selectHigh,
   output var  logic              dataCommandSelect,
   output var  logic              parallelSelect,
   output var  logic              cpuFamilySelect,
   output var  logic              readEnable,
   output var  logic              writeDirection,
   output var  logic [BUS_W-1:0]  busLine
);
   logic             hostOe;
   logic [BUS_W-1:0] hostData;
   logic [BUS_W-1:0] floatPat;

   // Resolved bus; a floating bus shows a moving pattern
   assign busLine = hostOe ? hostData : (dataOe[0] ? dataOut : floatPat);

   // Idle pins at time zero: strobe style, deselected
   initial
   begin
      selectLowN = 1'b0;
      selectHigh = 1'b0;
      dataCommandSelect = 1'b0;
      parallelSelect = 1'b1;
      cpuFamilySelect = 1'b0;
      readEnable = 1'b1;
      writeDirection = 1'b1;
      hostOe = 1'b0;
      hostData = BYTE_ZERO;
      floatPat = 8'h5A;
   end

   // Pattern flips every cycle so a float never reads as a value
   always @(posedge clk_sys)
      floatPat <= ~floatPat;

   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic sel(input logic on);
      selectHigh <= on;
      selectLowN <= ~on;
      hold(6);
   endtask

   // Mode change only while deselected; serial keeps its clock low
   task automatic set_mode(input busMode_t m);
      sel(1'b0);
      parallelSelect <= ~m[1];
      cpuFamilySelect <= m[0];
      readEnable <= ~m[0];
      writeDirection <= 1'b1;
      hostOe <= m[1];
      hostData <= BYTE_ZERO;
      hold(6);
      sel(1'b1);
   endtask

   // Parallel write in either style
   task automatic wr(input logic dc, input logic [BUS_W-1:0] b);
      dataCommandSelect <= dc;
      hostData <= b;
      hostOe <= 1'b1;
      if (cpuFamilySelect) writeDirection <= 1'b0;
      hold(6);
      if (cpuFamilySelect) readEnable <= 1'b1;
      else writeDirection <= 1'b0;
      hold(6);
      if (cpuFamilySelect) readEnable <= 1'b0;
      else writeDirection <= 1'b1;
      hold(6);
      hostOe <= 1'b0;
      writeDirection <= 1'b1;
      hold(4);
   endtask

   // Read start: strobe low or enable high with direction high
   task automatic rd(input logic dc);
      dataCommandSelect <= dc;
      hold(6);
      readEnable <= ~readEnable;
      hold(8);
   endtask

   task automatic rd_end;
      readEnable <= ~readEnable;
      hold(10);
   endtask

   // Serial bits, first n of b from the top down
   task automatic ser(input logic dc, input logic [BUS_W-1:0] b,
                      input int n);
      dataCommandSelect <= dc;
      for (int i = BUS_W - 1; i >= BUS_W - n; i--)
      begin
         hostData[SI_BIT] <= b[i];
         hold(4);
         hostData[SCL_BIT] <= 1'b1;
         hold(4);
         hostData[SCL_BIT] <= 1'b0;
      end
      hold(6);
   endtask
endmodule
`default_nettype wire

// file: lcd_module_host_bus_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_module_host_bus_port_tb_top;
   import lcd_port_pkg::*;

   typedef struct {
      busMode_t         mode;
      logic             dc;
      logic [BUS_W-1:0] b;
      logic [BUS_W:0]   exp;
   } row_t;

   logic             clk_sys, arst_n, initN, wrReady;
   logic             sLowN, sHigh, dcSel, parSel, famSel, rdEn, wrDir;
   logic [BUS_W-1:0] busLine, dataOut, dataOe, wrData;
   logic [BUS_W-1:0] displayByte, statusByte;
   logic             wrValid, wrIsData, displayRead, statusRead;
   logic             initActive, portBusy;
   logic [BUS_W:0]   gotQ[$];
   int               dispCnt, statCnt, errors, cmp_count;
   busMode_t         cur;
   row_t rows[7] = '{
      '{MODE_STROBE, 1'b1, 8'hA5, 9'h1A5}, '{MODE_STROBE, 1'b0, 8'h00, 9'h000},
      '{MODE_STROBE, 1'b1, 8'hFF, 9'h1FF}, '{MODE_ENABLE, 1'b1, 8'h3C, 9'h13C},
      '{MODE_ENABLE, 1'b0, 8'h81, 9'h081}, '{MODE_SERIAL, 1'b1, 8'h96, 9'h196},
      '{MODE_SERIAL, 1'b0, 8'h4B, 9'h04B}};

   lcd_host_port u_lcd_host_port (.clk_sys(clk_sys), .arst_n(arst_n),
      .selectLowN(sLowN), .selectHigh(sHigh), .initN(initN),
      .dataCommandSelect(dcSel), .parallelSelect(parSel),
      .cpuFamilySelect(famSel), .readEnable(rdEn), .writeDirection(wrDir),
      .dataIn(busLine), .dataOut(dataOut), .dataOe(dataOe),
      .wrValid(wrValid), .wrIsData(wrIsData), .wrData(wrData),
      .wrReady(wrReady), .displayRead(displayRead),
      .statusRead(statusRead), .displayByte(displayByte),
      .statusByte(statusByte), .initActive(initActive),
      .portBusy(portBusy));

   host_bus_model u_host_bus_model (.clk_sys(clk_sys), .dataOut(dataOut),
      .dataOe(dataOe), .selectLowN(sLowN), .selectHigh(sHigh),
      .dataCommandSelect(dcSel), .parallelSelect(parSel),
      .cpuFamilySelect(famSel), .readEnable(rdEn),
      .writeDirection(wrDir), .busLine(busLine));

   // Clock, 50 ns period
   initial
   begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // Collect accepted writes and read pulses
   always @(posedge clk_sys)
   begin
      if (wrValid === 1'b1 && wrReady === 1'b1)
         gotQ.push_back({wrIsData, wrData});
      if (displayRead === 1'b1) dispCnt++;
      if (statusRead === 1'b1) statCnt++;
   end

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk_val(input string nm, input logic [BUS_W:0] e,
                          input logic [BUS_W:0] g);
      cmp_count++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask

   task automatic chk_cnt(input string nm, input int e, input int g);
      cmp_count++;
      if (g != e)
      begin
         $display("wrong value %s expected %0d seen %0d", nm, e, g);
         errors++;
      end
   endtask

   // Bounded wait for the next accepted write
   task automatic expect_wr(input logic [BUS_W:0] e);
      int n;
      n = 0;
      while (gotQ.size() == 0 && n < 40)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (gotQ.size() == 0)
      begin
         $display("wrong value write expected %h seen none", e);
         errors++;
         close_out();
      end
      else
         chk_val("write", e, gotQ.pop_front());
   endtask

   // Main sequence
   initial
   begin
      arst_n = 1'b0;
      initN = 1'b1;
      wrReady = 1'b1;
      displayByte = 8'h3C;
      statusByte = 8'hC3;
      repeat (8) @(posedge clk_sys);
      chk_val("init in reset", 9'h001, {8'h00, initActive});
      chk_val("oe in reset", 9'h000, {1'b0, dataOe});
      arst_n <= 1'b1;
      u_host_bus_model.hold(8);
      chk_val("init after", 9'h000, {8'h00, initActive});
      $display("test reset done");
      cur = MODE_STROBE;
      u_host_bus_model.set_mode(cur);
      // Ordinary writes in all three styles
      foreach (rows[i])
      begin
         if (rows[i].mode != cur) u_host_bus_model.set_mode(rows[i].mode);
         cur = rows[i].mode;
         if (cur == MODE_SERIAL)
            u_host_bus_model.ser(rows[i].dc, rows[i].b, 8);
         else
            u_host_bus_model.wr(rows[i].dc, rows[i].b);
         expect_wr(rows[i].exp);
      end
      chk_val("serial oe", 9'h000, {1'b0, dataOe});
      $display("test writes done");
      // Partial serial byte dropped by deselect
      u_host_bus_model.ser(1'b1, 8'hF0, 4);
      u_host_bus_model.set_mode(MODE_SERIAL);
      u_host_bus_model.ser(1'b0, 8'h5A, 8);
      expect_wr(9'h05A);
      $display("test serial abort done");
      // Read strobe in serial mode is refused
      u_host_bus_model.rd(1'b1);
      chk_val("serial read oe", 9'h000, {1'b0, dataOe});
      u_host_bus_model.rd_end();
      chk_cnt("serial reads", 0, dispCnt + statCnt);
      $display("test serial read done");
      // Reads, display and status, both parallel styles
      for (int m = 0; m < 2; m++)
         for (int d = 0; d < 2; d++)
         begin
            u_host_bus_model.set_mode(busMode_t'(m));
            u_host_bus_model.rd(d[0]);
            chk_val("oe read", {1'b0, OE_ALL}, {1'b0, dataOe});
            chk_val("rdata", d ? 9'h03C : 9'h0C3, {1'b0, dataOut});
            u_host_bus_model.rd_end();
            chk_val("oe after", 9'h000, {1'b0, dataOe});
         end
      chk_cnt("display reads", 2, dispCnt);
      chk_cnt("status reads", 2, statCnt);
      $display("test reads done");
      // Deselected and init writes are ignored
      u_host_bus_model.set_mode(MODE_STROBE);
      u_host_bus_model.sel(1'b0);
      u_host_bus_model.wr(1'b1, 8'h77);
      chk_val("oe deselected", 9'h000, {1'b0, dataOe});
      u_host_bus_model.sel(1'b1);
      initN <= 1'b0;
      u_host_bus_model.wr(1'b1, 8'h11);
      chk_val("init active", 9'h001, {8'h00, initActive});
      initN <= 1'b1;
      u_host_bus_model.hold(10);
      chk_cnt("ignored writes", 0, gotQ.size());
      $display("test ignore done");
      // Stalled receiver: two kept, third lost
      wrReady <= 1'b0;
      u_host_bus_model.wr(1'b1, 8'h22);
      u_host_bus_model.wr(1'b0, 8'h33);
      u_host_bus_model.wr(1'b1, 8'h44);
      chk_val("busy", 9'h001, {8'h00, portBusy});
      wrReady <= 1'b1;
      expect_wr(9'h122);
      expect_wr(9'h033);
      u_host_bus_model.hold(20);
      chk_cnt("lost write", 0, gotQ.size());
      $display("test stall done");
      close_out();
   end
endmodule
`default_nettype wire
